// >>> drcsc_top.sv
// Dual RC system clock control with APB register access
//
// Added by the designer: the APB register port.
`include "drcsc_defines.svh"

//
// Behaviour
// (RULE1) Normal mode: fast clock divided 1 to 128
// (RULE2) Slow mode: slow clock divided by four
// (RULE3) Selected source feeds the rate divider
// (RULE4) Fast oscillator runs only with 16M option
// (RULE5) Slow oscillator clocks watchdog and slow mode
// (RULE6) Slow oscillator stops only sleep or green-slow-nowdt
// (RULE7) Control register at 095H, unused bits zero
// (RULE8) Stop bit set halts the fast oscillator
// (RULE9) Low clock select picks slow system clock
// (RULE10) Mode field: normal, sleep, green, reserved
// (RULE11) Resets warm up 2048 fast cycles
// (RULE12) Sleep wake-up warms up 32 fast cycles
// (RULE13) No extra fast oscillator start-up delay
// (RULE14) Sleep wake clears bit, resumes normal mode
// (RULE15) Green wake clears bit, keeps prior mode
// (RULE16) Slow mode leaves fast oscillator running
module drcsc_top
    import drcsc_pkg::*;
#(
    parameter int DIV_W = 8        // Divider counter width
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fast_osc_level,     // Fast oscillator pin
    input  wire logic        slow_osc_level,     // Slow oscillator pin
    input  wire logic        wake_pin,           // Wake-up source pin
    input  wire logic        internal_16m_option,
    input  wire logic [2:0]  fcpu_div_option,    // Divide by 2**n
    input  wire logic        watchdog_enable,
    output logic             fast_osc_enable,
    output logic             slow_osc_enable,
    output logic             watchdog_clk_tick,
    output logic             cpu_cycle_tick,
    output logic             core_run,
    output logic             sys_clk_slow
);

    // Three-stage synchronisers for the asynchronous pins
    logic [2:0] sync1;             // Metastability stage only
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] stable;            // Last agreed level
    logic [2:0] next_stable;
    logic [2:0] rise;              // Agreed rising edges
    wire logic  fast_edge = rise[0];
    wire logic  slow_edge = rise[1];
    wire logic  wake      = rise[2];
    // Control register fields
    logic       fast_stop;
    logic       low_sel;
    logic [1:0] cpu_mode;
    logic       next_fast_stop;
    logic       next_low_sel;
    logic [1:0] next_cpu_mode;
    // Mode state and warm-up counter
    drcsc_state_t state;
    drcsc_state_t next_state;
    logic [11:0]  warm_cnt;
    logic [11:0]  next_warm_cnt;
    // Bus slave registers
    logic        acc;              // Write or read takes effect
    logic        hit_oscillator_mode_control;
    logic        hit_status;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    // Registered outputs
    logic       next_fast_en;
    logic       next_slow_en;
    logic       next_wdt_tick;
    logic       next_core_run;
    logic       next_sys_slow;
    logic       src_tick;
    logic [7:0] div_m1;
    // Divisor for normal mode, 2**option minus one
    function automatic logic [7:0] fast_div_m1(input logic [2:0] opt);
        fast_div_m1 = 8'(({1'b0, 8'h01} << opt) - 9'h001);
    endfunction
    // Synchroniser: a change counts once stages two and three agree
    always_comb begin
        next_stable = (stable & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
        rise        = sync2 & sync3 & ~stable;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1  <= 3'h0;
            sync2  <= 3'h0;
            sync3  <= 3'h0;
            stable <= 3'h0;
        end else begin
            sync1  <= {wake_pin, slow_osc_level, fast_osc_level};
            sync2  <= sync1;
            sync3  <= sync2;
            stable <= next_stable;
        end
    end

    // Bus decode; index compared, byte lanes below word ignored
    assign hit_oscillator_mode_control   = (paddr[11:2] == `DRCSC_OSCILLATOR_MODE_CONTROL_INDEX);
    assign hit_status = (paddr[11:2] == `DRCSC_STATUS_INDEX);
    assign acc        = psel & penable & pready;

    // Mode sequencing and control register next values
    always_comb begin
        next_state     = state;
        next_warm_cnt  = warm_cnt;
        next_fast_stop = fast_stop;
        next_low_sel   = low_sel;
        next_cpu_mode  = cpu_mode;
        case (state)
            DRCSC_WARM: begin
                // Count fast edges directly, no start-up gap
                if (fast_edge) begin                         // RULE13
                    if (warm_cnt <= 12'h001) begin
                        next_state = DRCSC_RUN;              // RULE11
                    end else begin
                        next_warm_cnt = warm_cnt - 12'h001;
                    end
                end
            end
            DRCSC_RUN: begin
                if (cpu_mode == `DRCSC_MODE_SLEEP) begin
                    next_state = DRCSC_SLEEP;                // RULE10
                end else if (cpu_mode == `DRCSC_MODE_GREEN) begin
                    next_state = DRCSC_GREEN;                // RULE10
                end
            end
            DRCSC_SLEEP: begin
                if (wake) begin
                    // Back to normal mode with the stop bit cleared
                    next_state     = DRCSC_WARM;
                    next_warm_cnt  = `DRCSC_WARM_WAKE_CYC;   // RULE12
                    next_cpu_mode  = `DRCSC_MODE_NORMAL;     // RULE14
                    next_low_sel   = 1'b0;                   // RULE14
                    next_fast_stop = 1'b0;
                end
            end
            DRCSC_GREEN: begin
                if (wake) begin
                    // Clock selection kept, so the prior normal or slow mode resumes
                    next_state    = DRCSC_RUN;
                    next_cpu_mode = `DRCSC_MODE_NORMAL;      // RULE15
                end
            end
            default: begin
                next_state = DRCSC_WARM;
            end
        endcase
        // Software write; reserved mode code leaves the field as is
        if (acc && pwrite && hit_oscillator_mode_control) begin                 // RULE7
            next_fast_stop = pwdata[`DRCSC_STOP_BIT];        // RULE8
            next_low_sel   = pwdata[`DRCSC_LOWSEL_BIT];      // RULE9
            if (pwdata[`DRCSC_MODE_MSB:`DRCSC_MODE_LSB]
                    != `DRCSC_MODE_RESERVED) begin
                next_cpu_mode =
                    pwdata[`DRCSC_MODE_MSB:`DRCSC_MODE_LSB]; // RULE10
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= DRCSC_WARM;
            warm_cnt  <= `DRCSC_WARM_RESET_CYC;              // RULE11
            fast_stop <= `DRCSC_STOP_RESET;                  // RULE7
            low_sel   <= `DRCSC_LOWSEL_RESET;
            cpu_mode  <= `DRCSC_MODE_RESET;
        end else begin
            state     <= next_state;
            warm_cnt  <= next_warm_cnt;
            fast_stop <= next_fast_stop;
            low_sel   <= next_low_sel;
            cpu_mode  <= next_cpu_mode;
        end
    end

    // APB answer: data and ready prepared in the setup cycle
    always_comb begin
        next_pready  = psel & ~penable;
        next_pslverr = psel & ~penable & ~(hit_oscillator_mode_control | hit_status);
        next_prdata  = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            if (hit_oscillator_mode_control) begin
                // Bits 7..5 and 0 always read zero
                next_prdata[`DRCSC_STOP_BIT]   = fast_stop;   // RULE7
                next_prdata[`DRCSC_LOWSEL_BIT] = low_sel;
                next_prdata[`DRCSC_MODE_MSB:`DRCSC_MODE_LSB] = cpu_mode;
            end else if (hit_status) begin
                // Live state: mode state, enables, core running
                next_prdata[1:0] = state;
                next_prdata[2]   = fast_osc_enable;
                next_prdata[3]   = slow_osc_enable;
                next_prdata[4]   = core_run;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Oscillator enables and clock routing
    always_comb begin
        // Slow mode does not stop the fast oscillator by itself
        next_fast_en = internal_16m_option & ~fast_stop     // RULE4 RULE8
                       & (state != DRCSC_SLEEP);            // RULE16
        // Slow oscillator off only in sleep or green-slow-nowdt
        next_slow_en = !((state == DRCSC_SLEEP) ||
                         (state == DRCSC_GREEN && low_sel &&
                          !watchdog_enable));                // RULE6
        next_wdt_tick = slow_edge & slow_osc_enable;         // RULE5
        next_core_run = (next_state == DRCSC_RUN);
        next_sys_slow = low_sel;                             // RULE9
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_osc_enable   <= 1'b0;
            slow_osc_enable   <= 1'b1;
            watchdog_clk_tick <= 1'b0;
            core_run          <= 1'b0;
            sys_clk_slow      <= 1'b0;
        end else begin
            fast_osc_enable   <= next_fast_en;
            slow_osc_enable   <= next_slow_en;
            watchdog_clk_tick <= next_wdt_tick;
            core_run          <= next_core_run;
            sys_clk_slow      <= next_sys_slow;
        end
    end

    // Source select and divisor; slow ignores the option
    assign src_tick = low_sel ? (slow_edge & slow_osc_enable)  // RULE3 RULE5
                              : (fast_edge & fast_osc_enable);
    assign div_m1   = low_sel ? `DRCSC_SLOW_DIV_M1           // RULE2
                              : fast_div_m1(fcpu_div_option); // RULE1

    drcsc_divider #(
        .WIDTH      (DIV_W)
    ) u_div (
        .pclk       (pclk),
        .presetn    (presetn),
        .enable     (core_run),
        .src_tick   (src_tick),
        .divisor_m1 (DIV_W'(div_m1)),
        .cpu_tick   (cpu_cycle_tick)
    );

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_sleep_wake;
        state == DRCSC_SLEEP && wake;
    endsequence
    sequence s_normal_warm;
        state == DRCSC_WARM && warm_cnt == `DRCSC_WARM_WAKE_CYC
            && !low_sel && cpu_mode == `DRCSC_MODE_NORMAL;
    endsequence
    property p_fast_opt;
        fast_osc_enable |-> $past(internal_16m_option);
    endproperty
    a_fast_opt: assert property (p_fast_opt) // RULE4
        else $error("fast oscillator on without 16M option");
    property p_stop;
        $past(fast_stop) |-> !fast_osc_enable;
    endproperty
    a_stop: assert property (p_stop) // RULE8
        else $error("fast oscillator runs with stop bit set");
    property p_slow_off;
        !slow_osc_enable |-> $past(state == DRCSC_SLEEP ||
            (state == DRCSC_GREEN && low_sel && !watchdog_enable));
    endproperty
    a_slow_off: assert property (p_slow_off) // RULE6
        else $error("slow oscillator stopped outside allowed modes");
    property p_sleep_entry;
        state == DRCSC_RUN && cpu_mode == `DRCSC_MODE_SLEEP
            |=> state == DRCSC_SLEEP ##1 !slow_osc_enable;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) // RULE10
        else $error("sleep request did not stop the clocks");
    property p_warm_done;
        state == DRCSC_WARM && warm_cnt == 12'h001 && fast_edge
            |=> state == DRCSC_RUN ##1 core_run;
    endproperty
    a_warm_done: assert property (p_warm_done) // RULE11
        else $error("warm-up end did not start the core");
    property p_wake_warm;
        s_sleep_wake and !(acc && pwrite) |=> s_normal_warm;
    endproperty
    a_wake_warm: assert property (p_wake_warm) // RULE12
        else $error("sleep wake-up did not load the short warm-up");
    property p_sleep_clear;
        s_sleep_wake |=> cpu_mode != `DRCSC_MODE_SLEEP || $past(acc);
    endproperty
    a_sleep_clear: assert property (p_sleep_clear) // RULE14
        else $error("sleep bit not cleared on wake-up");
    property p_green_ret;
        state == DRCSC_GREEN && wake && !(acc && pwrite)
            |=> state == DRCSC_RUN && cpu_mode == `DRCSC_MODE_NORMAL
                && low_sel == $past(low_sel);
    endproperty
    a_green_ret: assert property (p_green_ret) // RULE15
        else $error("green wake-up did not restore prior mode");
    property p_read_zero;
        psel && penable && pready && !pwrite && hit_oscillator_mode_control
            |-> prdata[31:5] == 27'h0 && !prdata[0];
    endproperty
    a_read_zero: assert property (p_read_zero) // RULE7
        else $error("unused control bits read nonzero");
    property p_slow_keeps_fast;
        state == DRCSC_RUN && low_sel && !fast_stop
            && internal_16m_option |=> fast_osc_enable;
    endproperty
    a_slow_keeps_fast: assert property (p_slow_keeps_fast) // RULE16
        else $error("slow mode stopped the fast oscillator");

endmodule

// >>> drcsc_defines.svh
// Register map, field positions, reset values and warm-up counts
`ifndef DRCSC_DEFINES_SVH
`define DRCSC_DEFINES_SVH

// Register indices; byte address is four times the index
`define DRCSC_OSCILLATOR_MODE_CONTROL_INDEX      10'h095
`define DRCSC_STATUS_INDEX    10'h096

// Field positions in the oscillator mode control register
`define DRCSC_STOP_BIT        1
`define DRCSC_LOWSEL_BIT      2
`define DRCSC_MODE_LSB        3
`define DRCSC_MODE_MSB        4

// Reset value of each control bit
`define DRCSC_STOP_RESET      1'b0
`define DRCSC_LOWSEL_RESET    1'b0
`define DRCSC_MODE_RESET      2'h0

// CPU mode field encodings
`define DRCSC_MODE_NORMAL     2'h0
`define DRCSC_MODE_SLEEP      2'h1
`define DRCSC_MODE_GREEN      2'h2
`define DRCSC_MODE_RESERVED   2'h3

// Warm-up lengths in fast oscillator cycles
`define DRCSC_WARM_RESET_CYC  12'h800
`define DRCSC_WARM_WAKE_CYC   12'h020

// Slow mode divisor minus one (divide by four)
`define DRCSC_SLOW_DIV_M1     8'h03

`endif

// >>> drcsc_pkg.sv
// Types shared by the clock control block
package drcsc_pkg;

    // Operating state, Gray coded along warm, run, sleep
    typedef enum logic [1:0] {
        DRCSC_WARM  = 2'h0,
        DRCSC_RUN   = 2'h1,
        DRCSC_SLEEP = 2'h3,
        DRCSC_GREEN = 2'h2
    } drcsc_state_t;

endpackage

// >>> drcsc_divider.sv
// Instruction cycle divider counting source oscillator edges
module drcsc_divider
    import drcsc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             enable,
    input  wire logic             src_tick,
    input  wire logic [WIDTH-1:0] divisor_m1,
    output logic                  cpu_tick
);

    logic [WIDTH-1:0] count;       // Source edges seen in this cycle
    logic [WIDTH-1:0] next_count;
    logic             next_cpu_tick;

    // Count source edges, pulse once per full divisor
    always_comb begin
        next_count    = count;
        next_cpu_tick = 1'b0;
        if (!enable) begin
            // Halted core restarts with a fresh cycle
            next_count = '0;
        end else if (src_tick) begin
            if (count >= divisor_m1) begin
                next_count    = '0;
                next_cpu_tick = 1'b1;
            end else begin
                next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // Register counter and pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count    <= '0;
            cpu_tick <= 1'b0;
        end else begin
            count    <= next_count;
            cpu_tick <= next_cpu_tick;
        end
    end

endmodule

// >>> drcsc_top_tb_top.sv
// Self-checking bench for the dual RC clock control block
`include "drcsc_defines.svh"

// Compare two values, count it, report a mismatch at once
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end

module drcsc_top_tb_top
    import drcsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [11:0] CTRL = {`DRCSC_OSCILLATOR_MODE_CONTROL_INDEX, 2'b00};   // Control
    localparam logic [11:0] STAT = {`DRCSC_STATUS_INDEX, 2'b00}; // Status

    logic        pclk = 1'b0;          // Bus clock
    logic        presetn = 1'b0;       // Reset, active low
    logic        psel = 1'b0;          // APB select
    logic        penable = 1'b0;       // APB access phase
    logic        pwrite = 1'b0;        // APB direction
    logic [11:0] paddr = 12'h000;      // APB byte address
    logic [31:0] pwdata = 32'h0;       // APB write data
    logic [31:0] prdata;               // APB read data
    logic        pready;               // APB ready
    logic        pslverr;              // APB error
    logic        fast_osc_level = 1'b0; // Slowed fast oscillator view
    logic        slow_osc_level = 1'b0; // Slow oscillator view
    logic        wake_pin = 1'b0;      // Wake-up source
    logic        opt_16m = 1'b1;       // Fast oscillator option
    logic [2:0]  div_opt = 3'h0;       // Normal mode divisor option
    logic        wdog_en = 1'b1;       // Watchdog code option
    logic        fast_en;              // Fast oscillator enable
    logic        slow_en;              // Slow oscillator enable
    logic        wdog_tick;            // Watchdog clock pulse
    logic        cpu_tick;             // Instruction cycle pulse
    logic        core_run;             // Core may execute
    logic        sys_slow;             // Slow system clock selected
    logic [1:0]  fdiv = 2'h0;          // Fast level generator
    int          scnt = 0;             // Slow level generator
    int          fast_edges = 0;       // Fast rising edges driven
    int          cycles = 0;           // Timeout counter
    int          fails = 0;            // Mismatch count
    int          samples_checked = 0;  // Comparison count

    // Clock at 10 MHz
    always #50 pclk = ~pclk;

    // Oscillator levels: fast edge every 4 clocks, slow every 6.
    // Kept well below pclk so the synchronisers never miss an edge.
    always @(posedge pclk) begin
        fdiv <= fdiv + 2'h1;
        fast_osc_level <= fdiv[1];
        scnt <= (scnt == 5) ? 0 : scnt + 1;
        slow_osc_level <= (scnt < 3);
        if (fdiv == 2'h1) begin
            fast_edges <= fast_edges + 1;
        end
    end

    // Hang guard, about twice the expected run length
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 25000) begin
            fails++;
            $display("Error at %0t: timeout", $time);
            summarize();
        end
    end

    drcsc_top dut (
        .pclk                (pclk),
        .presetn             (presetn),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .fast_osc_level      (fast_osc_level),
        .slow_osc_level      (slow_osc_level),
        .wake_pin            (wake_pin),
        .internal_16m_option (opt_16m),
        .fcpu_div_option     (div_opt),
        .watchdog_enable     (wdog_en),
        .fast_osc_enable     (fast_en),
        .slow_osc_enable     (slow_en),
        .watchdog_clk_tick   (wdog_tick),
        .cpu_cycle_tick      (cpu_tick),
        .core_run            (core_run),
        .sys_clk_slow        (sys_slow)
    );

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Values read here are those the slave sees at this same edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        `CHK(pready, 1'b1)
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        `CHK(e, 1'b0)
    endtask

    // Register read compared with an expected word
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(r, x)
        `CHK(e, 1'b0)
    endtask

    // Let a few edges pass so mode changes land
    task automatic settle();
        repeat (4) @(negedge pclk);
    endtask

    // Bounded wait for core_run, returns fast edges seen meanwhile
    task automatic wait_run(output int edges);
        int n;
        int e0;
        n = 0;
        e0 = fast_edges;
        while (core_run !== 1'b1 && n < 12000) begin
            @(negedge pclk);
            n++;
        end
        edges = fast_edges - e0;
    endtask

    // Wait for the next pulse of the chosen tick
    task automatic wait_tick(input bit wd);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while ((wd ? wdog_tick : cpu_tick) !== 1'b1 && n < 3000);
    endtask

    // Clocks between two ticks, after skipping a possibly short one
    task automatic gap(input bit wd, output int g);
        wait_tick(wd);
        wait_tick(wd);
        g = 0;
        do begin
            @(negedge pclk);
            g++;
        end while ((wd ? wdog_tick : cpu_tick) !== 1'b1 && g < 3000);
    endtask

    // Wake pulse held until core_run rises or 12000 clocks pass
    task automatic wake(output int edges);
        @(posedge pclk);
        wake_pin <= 1'b1;
        wait_run(edges);
        @(posedge pclk);
        wake_pin <= 1'b0;
    endtask

    // Counts, verdict, end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [31:0] r;
        logic        e;
        int          n;
        int          k;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        `CHK(fast_en, 1'b1)
        `CHK(core_run, 1'b0)
        rd(CTRL, 32'h0);
        rd(STAT, 32'h0C);
        wait_run(n);
        `CHK(n >= 2040 && n <= 2051, 1'b1)
        rd(STAT, 32'h1D);
        $display("test reset warm-up done");

        // Reserved mode code refused, other bits taken; unmapped errs
        wr(CTRL, 32'hFFFF_FFFF);
        rd(CTRL, 32'h06);
        settle();
        `CHK(fast_en, 1'b0)
        `CHK(slow_en, 1'b1)
        `CHK(sys_slow, 1'b1)
        apb(1'b0, 12'h300, 32'h0, r, e);
        `CHK(e, 1'b1)
        `CHK(r, 32'h0)
        wr(CTRL, 32'h0);
        settle();
        `CHK(fast_en, 1'b1)
        `CHK(sys_slow, 1'b0)
        $display("test register access done");

        // Every normal divisor option, 4 clocks per fast edge
        for (k = 0; k < 8; k++) begin
            @(posedge pclk);
            div_opt <= k[2:0];
            gap(1'b0, n);
            `CHK(n, 4 << k)
        end
        $display("test normal divider done");

        // Slow mode: divisor option ignored, fast stays on
        wr(CTRL, 32'h04);
        settle();
        `CHK(fast_en, 1'b1)
        gap(1'b0, n);
        `CHK(n, 24)
        gap(1'b1, n);
        `CHK(n, 6)
        $display("test slow mode done");

        // Green from slow, watchdog off: slow oscillator halts
        @(posedge pclk);
        wdog_en <= 1'b0;
        wr(CTRL, 32'h14);
        settle();
        `CHK(core_run, 1'b0)
        `CHK(slow_en, 1'b0)
        wake(n);
        `CHK(core_run, 1'b1)
        rd(CTRL, 32'h04);
        `CHK(sys_slow, 1'b1)
        // Green from normal, watchdog on: slow oscillator keeps going
        wdog_en <= 1'b1;
        wr(CTRL, 32'h10);
        settle();
        `CHK(core_run, 1'b0)
        `CHK(slow_en, 1'b1)
        wake(n);
        rd(CTRL, 32'h00);
        $display("test green mode done");

        // Sleep from slow with stop set: all halts, wakes normal
        wr(CTRL, 32'h0E);
        settle();
        `CHK(core_run, 1'b0)
        `CHK(fast_en, 1'b0)
        `CHK(slow_en, 1'b0)
        rd(STAT, {30'h0, DRCSC_SLEEP});
        wake(n);
        `CHK(n >= 32 && n <= 35, 1'b1)
        rd(CTRL, 32'h00);
        `CHK(sys_slow, 1'b0)
        `CHK(fast_en, 1'b1)
        $display("test sleep mode done");

        // Second reset with the 16M option off
        wr(CTRL, 32'h02);
        opt_16m <= 1'b0;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        `CHK(fast_en, 1'b0)
        rd(CTRL, 32'h0);
        $display("test option reset done");
        summarize();
    end

endmodule
